// *** rtl/gpio_alternate_function_mux.sv ***
// Operation
// - each pad connects exactly one source, plain GPIO or one chosen alternate.
// - every bit offers three alternate positions, each input, output or bidirectional.
// - a position with no assigned signal is reserved and gives no alternate function.
// - bit indices are logical GPIO numbers, used directly for all decoding.
// - after reset every bit is a GPIO input, except bits 29 and 14.
// - after reset bit 29 carries the PWM output as an open-drain output.
// - bit 14 defaults to test data output only when strap is low in reset.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module gpio_alternate_function_mux (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  // reset strap
  input  wire logic        bus_data_strap_bit_i,
  // peripheral side, one group per alternate position
  input  wire logic [31:0] alt1_out_i,
  input  wire logic [31:0] alt1_oe_i,
  output logic      [31:0] alt1_in_o,
  input  wire logic [31:0] alt2_out_i,
  input  wire logic [31:0] alt2_oe_i,
  output logic      [31:0] alt2_in_o,
  input  wire logic [31:0] alt3_out_i,
  input  wire logic [31:0] alt3_oe_i,
  output logic      [31:0] alt3_in_o,
  // pads of general_io_bank_zero
  input  wire logic [31:0] pad_in_i,
  output logic      [31:0] pad_out_o,
  output logic      [31:0] pad_oe_o
);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic        rst_meta;
  logic        rst_q;
  logic [31:0] pad_s;
  logic        strap_s;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_q    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_q    <= rst_meta;
    end
  end

  gpio_sync #(.WIDTH(32)) u_pad_sync (
    .clk_i (clk_i),
    .d_i   (pad_in_i),
    .q_o   (pad_s)
  );

  gpio_sync #(.WIDTH(1)) u_strap_sync (
    .clk_i (clk_i),
    .d_i   (bus_data_strap_bit_i),
    .q_o   (strap_s)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [1:0]  sel_q [32];
  logic [31:0] dir;
  logic [31:0] gout;
  logic [31:0] od;
  logic        strap_done;
  logic        wr_lo;
  logic        wr_hi;

  assign wr_lo = we_i && (addr_i == gpio_mux_pkg::OFS_SEL_LO);
  assign wr_hi = we_i && (addr_i == gpio_mux_pkg::OFS_SEL_HI);

  // strap taken once, on the first cycle after the released reset
  always_ff @(posedge clk_i or negedge rst_q)
  begin
    if (!rst_q)
      strap_done <= 1'b0;
    else
      strap_done <= 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_sel
      localparam logic [1:0] SEL_RST = (g == gpio_mux_pkg::PWM_BIT) ? gpio_mux_pkg::PWM_SEL_RST
                                                                    : gpio_mux_pkg::SEL_GPIO;
      always_ff @(posedge clk_i or negedge rst_q)
      begin
        if (!rst_q)
          sel_q[g] <= SEL_RST;
        else if ((g < 16) ? wr_lo : wr_hi)
          sel_q[g] <= wdata_i[2*(g%16) +: 2];  // logical index picks the field
        else if (g == gpio_mux_pkg::TDO_BIT && !strap_done)
          sel_q[g] <= (strap_s == gpio_mux_pkg::STRAP_TDO_LVL) ? gpio_mux_pkg::TDO_SEL_STRAP
                                                               : gpio_mux_pkg::SEL_GPIO;
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      dir  <= gpio_mux_pkg::GPIO_DIR_RST;  // all inputs
      gout <= gpio_mux_pkg::GPIO_OUT_RST;
      od   <= gpio_mux_pkg::OPEN_DRN_RST;
    end
    else if (we_i)
    begin
      if (addr_i == gpio_mux_pkg::OFS_GPIO_DIR)
        dir <= wdata_i;
      if (addr_i == gpio_mux_pkg::OFS_GPIO_OUT)
        gout <= wdata_i;
      if (addr_i == gpio_mux_pkg::OFS_OPEN_DRN)
        od <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // per-bit pad multiplexer
  // ----------------------------------------------------------------
  logic [2:0][31:0] alt_out;
  logic [2:0][31:0] alt_oe;
  logic [31:0]      next_pad_out;
  logic [31:0]      next_pad_oe;
  logic [2:0][31:0] next_alt_in;
  logic [31:0]      sel_rsvd;
  logic [31:0]      sel_gpio;
  logic [2:0][31:0] sel_alt;

  assign alt_out = {alt3_out_i, alt2_out_i, alt1_out_i};
  assign alt_oe  = {alt3_oe_i, alt2_oe_i, alt1_oe_i};

  generate
    for (g = 0; g < 32; g++)
    begin : g_mux
      logic [1:0] pos;
      logic       src_o;
      logic       src_e;

      assign pos = sel_q[g] - 2'h1;
      assign sel_gpio[g] = (sel_q[g] == gpio_mux_pkg::SEL_GPIO);

      for (genvar k = 0; k < 3; k++)
      begin : g_pos
        assign sel_alt[k][g] = !sel_gpio[g] && (pos == 2'(k));
        // a peripheral sees the pad only when its position is chosen and can receive
        assign next_alt_in[k][g] = sel_alt[k][g] && gpio_mux_pkg::ALT_VALID[k][g]
                                   && !gpio_mux_pkg::ALT_OUT[k][g] && pad_s[g];
      end

      assign sel_rsvd[g] = !sel_gpio[g] && !gpio_mux_pkg::ALT_VALID[pos][g];

      // exactly one source reaches the pad; a reserved choice leaves it an input
      always_comb
      begin
        src_o = 1'b0;
        src_e = 1'b0;
        if (sel_gpio[g])
        begin
          src_o = gout[g];
          src_e = dir[g];
        end
        else if (!sel_rsvd[g])
        begin
          src_o = alt_out[pos][g];
          if (gpio_mux_pkg::ALT_OUT[pos][g])
            src_e = 1'b1;
          else if (gpio_mux_pkg::ALT_BIDIR[pos][g])
            src_e = alt_oe[pos][g];
        end
      end

      // open drain only ever pulls low, an external pull-up gives the high
      assign next_pad_out[g] = od[g] ? 1'b0 : src_o;
      assign next_pad_oe[g]  = od[g] ? (src_e && !src_o) : src_e;
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      pad_out_o <= 32'h0000_0000;
      pad_oe_o  <= 32'h0000_0000;
      alt1_in_o <= 32'h0000_0000;
      alt2_in_o <= 32'h0000_0000;
      alt3_in_o <= 32'h0000_0000;
    end
    else
    begin
      pad_out_o <= next_pad_out;
      pad_oe_o  <= next_pad_oe;
      alt1_in_o <= next_alt_in[0];
      alt2_in_o <= next_alt_in[1];
      alt3_in_o <= next_alt_in[2];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [31:0] sel_lo_word;
  logic [31:0] sel_hi_word;

  always_comb
  begin
    sel_lo_word = 32'h0000_0000;
    sel_hi_word = 32'h0000_0000;
    for (int i = 0; i < 16; i++)
    begin
      sel_lo_word[2*i +: 2] = sel_q[i];
      sel_hi_word[2*i +: 2] = sel_q[i+16];
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (re_i)
    begin
      unique case (addr_i)
        gpio_mux_pkg::OFS_SEL_LO:   next_rdata = sel_lo_word;
        gpio_mux_pkg::OFS_SEL_HI:   next_rdata = sel_hi_word;
        gpio_mux_pkg::OFS_GPIO_DIR: next_rdata = dir;
        gpio_mux_pkg::OFS_GPIO_OUT: next_rdata = gout;
        gpio_mux_pkg::OFS_OPEN_DRN: next_rdata = od;
        gpio_mux_pkg::OFS_PAD_IN:   next_rdata = pad_s;
        gpio_mux_pkg::OFS_SEL_RSVD: next_rdata = sel_rsvd;
        default:                    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_q)
  begin
    if (!rst_q)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= next_rdata;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [1:0]  wlow;
  logic [31:0] in_only1;

  assign wlow     = wdata_i[1:0];
  assign in_only1 = gpio_mux_pkg::ALT_VALID[0] & ~gpio_mux_pkg::ALT_OUT[0] & ~gpio_mux_pkg::ALT_BIDIR[0];

  chk_one_route: assert property (
    @(posedge clk_i) disable iff (!rst_q)
    ((alt1_in_o & alt2_in_o) | (alt1_in_o & alt3_in_o) | (alt2_in_o & alt3_in_o)) == 32'h0000_0000)
    else $error("pad routed to more than one peripheral");

  chk_out_drive: assert property (
    @(posedge clk_i) disable iff (!rst_q)
    ##1 (($past(sel_alt[0]) & gpio_mux_pkg::ALT_OUT[0] & ~$past(od) & ~pad_oe_o) == 32'h0000_0000))
    else $error("output-only alternate not driving its pad");

  chk_in_release: assert property (
    @(posedge clk_i) disable iff (!rst_q)
    ##1 (($past(sel_alt[0]) & in_only1 & pad_oe_o) == 32'h0000_0000))
    else $error("input-only alternate drives its pad");

  chk_reserved_quiet: assert property (
    @(posedge clk_i) disable iff (!rst_q)
    ##1 (($past(sel_rsvd) & (pad_oe_o | alt1_in_o | alt2_in_o | alt3_in_o)) == 32'h0000_0000))
    else $error("reserved position is active");

  chk_index_decode: assert property (
    @(posedge clk_i) disable iff (!rst_q)
    wr_lo |=> sel_q[0] == $past(wlow))
    else $error("sel field of bit 0 not taken from its logical field");

  chk_reset_inputs: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_q) |-> (dir == 32'h0000_0000) && ((sel_gpio | 32'h2000_4000) == 32'hFFFF_FFFF))
    else $error("bit not a plain input after reset");

  chk_pwm_default: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_q) |-> (sel_q[29] == gpio_mux_pkg::SEL_ALT1) && od[29] ##1 !pad_out_o[29])
    else $error("bit 29 not open-drain pulse output after reset");

  chk_strap_tdo: assert property (
    @(posedge clk_i) disable iff (!rst_q)
    $rose(strap_done) |-> ((sel_q[14] == gpio_mux_pkg::SEL_ALT1) == !$past(strap_s)))
    else $error("bit 14 default disagrees with strap");

  chk_gpio_dir: assert property (
    @(posedge clk_i) disable iff (!rst_q)
    ##1 (pad_oe_o & $past(sel_gpio) & ~$past(od)) == ($past(dir) & $past(sel_gpio) & ~$past(od)))
    else $error("gpio direction not reflected on pad enable");

endmodule

// *** rtl/gpio_mux_pkg.sv ***
package gpio_mux_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_BITS = 32;
  localparam int unsigned NUM_ALT  = 3;
  localparam int unsigned ADDR_W   = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SEL_LO    = 8'h00;  // sel fields of bits 0..15
  localparam logic [7:0] OFS_SEL_HI    = 8'h04;  // sel fields of bits 16..31
  localparam logic [7:0] OFS_GPIO_DIR  = 8'h08;
  localparam logic [7:0] OFS_GPIO_OUT  = 8'h0C;
  localparam logic [7:0] OFS_OPEN_DRN  = 8'h10;
  localparam logic [7:0] OFS_PAD_IN    = 8'h14;
  localparam logic [7:0] OFS_SEL_RSVD  = 8'h18;

  // ----------------------------------------------------------------
  // selection field codes, two bits per pad
  // ----------------------------------------------------------------
  localparam int unsigned SEL_W    = 2;
  localparam logic [1:0]  SEL_GPIO = 2'h0;
  localparam logic [1:0]  SEL_ALT1 = 2'h1;
  localparam logic [1:0]  SEL_ALT2 = 2'h2;
  localparam logic [1:0]  SEL_ALT3 = 2'h3;

  // ----------------------------------------------------------------
  // connection map per position, index 0 = first alternate
  // ----------------------------------------------------------------
  localparam logic [2:0][31:0] ALT_VALID = {32'h0066_FFFC, 32'hE01F_FFDC, 32'hFFFC_FFFC};
  localparam logic [2:0][31:0] ALT_OUT   = {32'h0002_9810, 32'h6003_0F1C, 32'hA000_4768};
  localparam logic [2:0][31:0] ALT_BIDIR = {32'h0000_0600, 32'h8018_4000, 32'h5FFC_0004};

  // ----------------------------------------------------------------
  // reset defaults
  // ----------------------------------------------------------------
  localparam int unsigned PWM_BIT       = 29;
  localparam int unsigned TDO_BIT       = 14;
  localparam logic [31:0] OPEN_DRN_RST  = 32'h2000_0000;
  localparam logic [31:0] GPIO_DIR_RST  = 32'h0000_0000;
  localparam logic [31:0] GPIO_OUT_RST  = 32'h0000_0000;
  localparam logic [1:0]  PWM_SEL_RST   = SEL_ALT1;
  localparam logic [1:0]  TDO_SEL_STRAP = SEL_ALT1;
  localparam logic        STRAP_TDO_LVL = 1'b0;

endpackage

// *** rtl/gpio_sync.sv ***
`timescale 1ns/1ps

module gpio_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock
  input  wire logic             clk_i,
  // async levels in, synchronised out
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  // no reset: the chain keeps tracking while reset is held, so a strap is
  // already settled at the moment the reset is released
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i)
  begin
    meta <= d_i;
    q_o  <= meta;
  end

endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_i;
  logic        rst_n_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        we_i;
  logic        re_i;
  logic [31:0] rdata_o;
  logic        strap;
  logic [31:0] ao [3];
  logic [31:0] aoe [3];
  logic [31:0] ai [3];
  logic [31:0] pad_in;
  logic [31:0] pad_out_o;
  logic [31:0] pad_oe_o;
  logic [31:0] v;
  logic [31:0] o;
  logic [31:0] b;
  int          err_count;
  int          n_tests;

  gpio_alternate_function_mux uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .bus_data_strap_bit_i(strap),
    .alt1_out_i(ao[0]), .alt1_oe_i(aoe[0]), .alt1_in_o(ai[0]),
    .alt2_out_i(ao[1]), .alt2_oe_i(aoe[1]), .alt2_in_o(ai[1]),
    .alt3_out_i(ao[2]), .alt3_oe_i(aoe[2]), .alt3_in_o(ai[2]),
    .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // the write strobe is left up so back-to-back calls never assign twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    we_i    <= 1'b1;
    re_i    <= 1'b0;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] e);
    we_i   <= 1'b0;
    re_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask

  task automatic idle();
    we_i <= 1'b0;
    re_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic do_reset(input logic s);
    rst_n_i <= 1'b0;
    strap   <= s;
    we_i    <= 1'b0;
    re_i    <= 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the whole run needs well under a thousand cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4000) @(posedge clk_i);
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    addr_i  = 8'h00;
    wdata_i = 32'h0000_0000;
    pad_in  = 32'hA5A5_5A5A;
    for (int j = 0; j < 3; j++)
    begin
      ao[j]  = 32'h0000_0000;
      aoe[j] = 32'h0000_0000;
    end
    do_reset(1'b1);
    chkrd(gpio_mux_pkg::OFS_SEL_LO, 32'h0000_0000);
    `CHK(pad_oe_o, 32'h2000_0000)
    `CHK(pad_out_o, 32'h0000_0000)
    $display("strap high reset done");
    do_reset(1'b0);
    `CHK(pad_oe_o, 32'h2000_4000)
    chkrd(gpio_mux_pkg::OFS_SEL_LO, 32'h1000_0000);
    chkrd(gpio_mux_pkg::OFS_SEL_HI, 32'h0400_0000);
    chkrd(gpio_mux_pkg::OFS_OPEN_DRN, 32'h2000_0000);
    chkrd(gpio_mux_pkg::OFS_GPIO_DIR, 32'h0000_0000);
    chkrd(gpio_mux_pkg::OFS_GPIO_OUT, 32'h0000_0000);
    ao[0] <= 32'h2000_4000;
    idle();
    `CHK(pad_oe_o, 32'h0000_4000)
    `CHK(pad_out_o, 32'h0000_4000)
    $display("strap low reset done");
    // each position in turn on every pad; outputs first, then bidir enables
    for (int k = 1; k <= 3; k++)
    begin
      v = gpio_mux_pkg::ALT_VALID[k-1];
      o = gpio_mux_pkg::ALT_OUT[k-1];
      b = gpio_mux_pkg::ALT_BIDIR[k-1];
      for (int j = 0; j < 3; j++)
      begin
        ao[j]  <= 32'hFFFF_FFFF;
        aoe[j] <= 32'h0000_0000;
      end
      wr(gpio_mux_pkg::OFS_OPEN_DRN, 32'h0000_0000);
      wr(gpio_mux_pkg::OFS_SEL_LO, {16{2'(k)}});
      wr(gpio_mux_pkg::OFS_SEL_HI, {16{2'(k)}});
      idle();
      `CHK(pad_oe_o, v & o)
      `CHK(pad_out_o & v & o, v & o)
      chkrd(gpio_mux_pkg::OFS_SEL_RSVD, ~v);
      for (int j = 0; j < 3; j++)
        aoe[j] <= 32'hFFFF_FFFF;
      idle();
      `CHK(pad_oe_o, v & (o | b))
      `CHK(pad_out_o & ~v, 32'h0000_0000)
      for (int j = 0; j < 3; j++)
        `CHK(ai[j], (j == k - 1) ? (v & ~o & pad_in) : 32'h0000_0000)
      $display("alternate position %0d done", k);
    end
    wr(gpio_mux_pkg::OFS_SEL_LO, 32'h0000_0000);
    wr(gpio_mux_pkg::OFS_SEL_HI, 32'h0000_0000);
    wr(gpio_mux_pkg::OFS_OPEN_DRN, 32'h0000_0030);
    wr(gpio_mux_pkg::OFS_GPIO_DIR, 32'h0000_00F0);
    wr(gpio_mux_pkg::OFS_GPIO_OUT, 32'h0000_0050);
    idle();
    `CHK(pad_oe_o, 32'h0000_00E0)
    `CHK(pad_out_o, 32'h0000_0040)
    `CHK(ai[0] | ai[1] | ai[2], 32'h0000_0000)
    $display("plain gpio done");
    wr(gpio_mux_pkg::OFS_PAD_IN, 32'h0000_0000);
    chkrd(gpio_mux_pkg::OFS_PAD_IN, 32'hA5A5_5A5A);
    wr(8'h1C, 32'hFFFF_FFFF);
    chkrd(8'h1C, 32'h0000_0000);
    chkrd(gpio_mux_pkg::OFS_GPIO_DIR, 32'h0000_00F0);
    // one field alone in the high word must land on bit 29 only
    wr(gpio_mux_pkg::OFS_SEL_HI, 32'h0400_0000);
    idle();
    `CHK(rdata_o, 32'h0000_0000)
    `CHK(pad_oe_o, 32'h2000_00E0)
    `CHK(pad_out_o, 32'h2000_0040)
    $display("register refusals done");
    close_out();
  end
endmodule
